// ---- design/dct_map.svh ----
// register offsets, field positions, reset values and mode codes
`ifndef DCT_MAP_SVH
`define DCT_MAP_SVH

`define DCT_OFF_CTRL1 6'h00
`define DCT_OFF_LOW1 6'h04
`define DCT_OFF_HIGH1 6'h08
`define DCT_OFF_CTRL2 6'h0c
`define DCT_OFF_LOW2 6'h10
`define DCT_OFF_HIGH2 6'h14
`define DCT_OFF_T3CTRL 6'h18
`define DCT_OFF_STATUS 6'h1c
`define DCT_OFF_IRQEN 6'h20
`define DCT_OFF_PINCFG 6'h24

`define DCT_CTRL_MASK 8'h3f
`define DCT_T3_SEL1_BIT 3
`define DCT_T3_SEL2_BIT 6
`define DCT_PIN_SEL_BIT 0
`define DCT_PIN_DIRC_BIT 1
`define DCT_PIN_DIRB_BIT 2
`define DCT_PIN_LATC_BIT 3
`define DCT_PIN_LATB_BIT 4
`define DCT_PINCFG_RESET 8'h07
`define DCT_PINCFG_MASK 8'h1f

`define DCT_MODE_OFF 4'h0
`define DCT_MODE_FALL 4'h4
`define DCT_MODE_RISE 4'h5
`define DCT_MODE_DIV4 4'h6
`define DCT_MODE_DIV16 4'h7
`define DCT_MODE_SPECIAL 4'hb
`define DCT_MODE_CAP_TOP 2'b01
`define DCT_MODE_PWM_TOP 2'b11

`endif

// ---- design/dct_pkg.sv ----
// types shared by the dual capture timer select block
package dct_pkg;
  typedef enum logic [1:0] {
    DCT_BASE_ONE,
    DCT_BASE_THREE,
    DCT_BASE_TWO
  } dct_base_t;

  typedef enum logic {
    DCT_BUS_IDLE,
    DCT_BUS_DONE
  } dct_bus_t;
endpackage

// ---- design/dct_top.sv ----
// two capture channels with shared timer selection and avalon registers
//
// Summary of operation
// (RULE1) each channel has low, high value bytes and control, all read/write
// (RULE2) capture/compare use timer one or three, pwm uses timer two
// (RULE3) timer three control bits pick timer one or three per channel
// (RULE4) both channels run together and may share one timer
// (RULE5) in capture each channel may use a different time base
// (RULE6) channel two special trigger resets its timer and starts conversion
// (RULE7) either trigger resets its timer, only channel two starts conversion
// (RULE8) pwm channels ignore capture/compare ones and share timer two
// (RULE9) channel two pin is port c bit one when select is 1, else port b
// (RULE10) software sets port direction for channel two wherever routed
// (RULE11) capture copies the full 16-bit timer value into high and low
// (RULE12) event is falling, rising, every 4th or every 16th rising edge
// (RULE13) mode codes 0100, 0101, 0110, 0111 choose those four events
// (RULE14) mode 0000 disables the channel and resets its state
// (RULE15) every capture sets the event flag, only software clears it
// (RULE16) a new capture overwrites an unread value
// (RULE17) software should make the capture pin an input
// (RULE18) a pin driven as output feeds its own level to the detector
// (RULE19) timer in asynchronous counter mode gives no capture
// (RULE20) software masks the interrupt and clears the flag on mode change
// (RULE21) prescaler clears when off or out of capture mode
// (RULE22) switching prescale settings keeps the prescaler count
// (RULE23) software writes zero before a new capture mode
// (RULE24) edges found on the system clock, divided capture on final edge
//
// The Avalon-MM register port and the register addresses were left to the implementer.
`include "dct_map.svh"

module dct_top
  import dct_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic channel_one_pin,
  input wire logic port_c_bit_one_pin,
  input wire logic port_b_bit_three_pin,
  output logic port_c_bit_one_out,
  output logic port_c_bit_one_oe_n,
  output logic port_b_bit_three_out,
  output logic port_b_bit_three_oe_n,
  input wire logic [15:0] timer_one_value,
  input wire logic [15:0] timer_three_value,
  input wire logic timer_one_async,
  input wire logic timer_three_async,
  input wire logic compare_match_one,
  input wire logic compare_match_two,
  output logic timer_one_reset,
  output logic timer_three_reset,
  output logic adc_start,
  output logic [1:0] channel_irq_req
);

  function automatic logic is_capture(input logic [7:0] ctl);
    return ctl[3:2] == `DCT_MODE_CAP_TOP;
  endfunction

  function automatic dct_base_t base_of(input int ch, input logic [7:0] ctl,
                                        input logic [7:0] t3);
    dct_base_t b;
    b = DCT_BASE_ONE;
    if (ctl[3:2] == `DCT_MODE_PWM_TOP) begin
      b = DCT_BASE_TWO; // [RULE8]
    end else if (t3[`DCT_T3_SEL2_BIT]) begin
      b = DCT_BASE_THREE;
    end else if (t3[`DCT_T3_SEL1_BIT] && ch == 1) begin
      b = DCT_BASE_THREE;
    end
    return b;
  endfunction

  function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
    return a[5:2] == off[5:2];
  endfunction

  dct_bus_t bus_state;
  logic wr_go;
  logic [7:0] wbyte;
  logic [7:0] ctrl [2];
  logic [7:0] val_lo [2];
  logic [7:0] val_hi [2];
  logic [7:0] t3ctrl;
  logic [7:0] pincfg;
  logic [1:0] flag;
  logic [1:0] irq_en;
  logic [2:0] sync [3];
  logic [2:0] filt;
  logic [1:0] lvl;
  logic [1:0] prev;
  logic [1:0] rise;
  logic [1:0] fall;
  logic [3:0] psc [2];
  logic [1:0] ev;
  logic [1:0] trig;
  dct_base_t base [2];
  logic [15:0] tval [2];
  logic [1:0] tasync;
  logic [31:0] rd_word;

  assign wr_go = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wbyte = avs_writedata[7:0];

  // register bus: one wait cycle, the access lands when waitrequest is low
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_state <= DCT_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      unique case (bus_state)
        DCT_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= DCT_BUS_DONE;
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_word : 32'h0000_0000;
          end
        end
        DCT_BUS_DONE: begin
          bus_state <= DCT_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // unmapped offsets read as zero, reserved bits read as zero except in timer three control, which reads back all eight bits as written
  always_comb begin
    rd_word = 32'h0000_0000;
    if (hit(avs_address, `DCT_OFF_CTRL1)) begin
      rd_word[7:0] = ctrl[0]; // [RULE1]
    end else if (hit(avs_address, `DCT_OFF_LOW1)) begin
      rd_word[7:0] = val_lo[0];
    end else if (hit(avs_address, `DCT_OFF_HIGH1)) begin
      rd_word[7:0] = val_hi[0];
    end else if (hit(avs_address, `DCT_OFF_CTRL2)) begin
      rd_word[7:0] = ctrl[1];
    end else if (hit(avs_address, `DCT_OFF_LOW2)) begin
      rd_word[7:0] = val_lo[1];
    end else if (hit(avs_address, `DCT_OFF_HIGH2)) begin
      rd_word[7:0] = val_hi[1];
    end else if (hit(avs_address, `DCT_OFF_T3CTRL)) begin
      rd_word[7:0] = t3ctrl;
    end else if (hit(avs_address, `DCT_OFF_STATUS)) begin
      rd_word[7:0] = {2'b00, base[1], base[0], flag};
    end else if (hit(avs_address, `DCT_OFF_IRQEN)) begin
      rd_word[7:0] = {6'h00, irq_en};
    end else if (hit(avs_address, `DCT_OFF_PINCFG)) begin
      rd_word[7:0] = pincfg;
    end
  end

  // control, timer selection, pin and enable registers
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl[0] <= 8'h00;
      ctrl[1] <= 8'h00;
      t3ctrl <= 8'h00;
      pincfg <= `DCT_PINCFG_RESET; // [RULE9]
      irq_en <= 2'b00;
    end else if (wr_go) begin
      if (hit(avs_address, `DCT_OFF_CTRL1)) begin
        ctrl[0] <= wbyte & `DCT_CTRL_MASK; // [RULE1]
      end
      if (hit(avs_address, `DCT_OFF_CTRL2)) begin
        ctrl[1] <= wbyte & `DCT_CTRL_MASK;
      end
      if (hit(avs_address, `DCT_OFF_T3CTRL)) begin
        t3ctrl <= wbyte; // [RULE3]
      end
      if (hit(avs_address, `DCT_OFF_PINCFG)) begin
        pincfg <= wbyte & `DCT_PINCFG_MASK;
      end
      if (hit(avs_address, `DCT_OFF_IRQEN)) begin
        irq_en <= wbyte[1:0];
      end
    end
  end

  // port pins: low enable while driving the latch
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      port_c_bit_one_out <= 1'b0;
      port_c_bit_one_oe_n <= 1'b1;
      port_b_bit_three_out <= 1'b0;
      port_b_bit_three_oe_n <= 1'b1;
    end else begin
      port_c_bit_one_out <= pincfg[`DCT_PIN_LATC_BIT];
      port_c_bit_one_oe_n <= pincfg[`DCT_PIN_DIRC_BIT]; // [RULE10]
      port_b_bit_three_out <= pincfg[`DCT_PIN_LATB_BIT];
      port_b_bit_three_oe_n <= pincfg[`DCT_PIN_DIRB_BIT];
    end
  end

  // three-stage synchronisers; a change counts when stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int p = 0; p < 3; p++) begin
        sync[p] <= 3'b000;
      end
      filt <= 3'b000;
    end else begin
      sync[0] <= {sync[0][1:0], channel_one_pin};
      sync[1] <= {sync[1][1:0], port_c_bit_one_pin};
      sync[2] <= {sync[2][1:0], port_b_bit_three_pin};
      for (int p = 0; p < 3; p++) begin
        if (sync[p][1] == sync[p][2]) begin
          filt[p] <= sync[p][2]; // [RULE24]
        end
      end
    end
  end

  // channel two input follows the routed pin, or its own latch when driven
  always_comb begin
    lvl[0] = filt[0];
    if (pincfg[`DCT_PIN_SEL_BIT]) begin // [RULE9]
      lvl[1] = pincfg[`DCT_PIN_DIRC_BIT] ? filt[1] // [RULE18]
                                          : pincfg[`DCT_PIN_LATC_BIT];
    end else begin
      lvl[1] = pincfg[`DCT_PIN_DIRB_BIT] ? filt[2]
                                          : pincfg[`DCT_PIN_LATB_BIT];
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev <= 2'b00;
    end else begin
      prev <= lvl; // [RULE24]
    end
  end

  assign rise = lvl & ~prev;
  assign fall = ~lvl & prev;

  // time base per channel and capture events
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      base[c] = base_of(c, ctrl[c], t3ctrl); // [RULE2] [RULE3] [RULE5]
      tval[c] = (base[c] == DCT_BASE_THREE) ? timer_three_value
                                             : timer_one_value; // [RULE4]
      tasync[c] = (base[c] == DCT_BASE_THREE) ? timer_three_async
                                               : timer_one_async;
      ev[c] = 1'b0;
      if (!tasync[c]) begin // [RULE19]
        unique case (ctrl[c][3:0])
          `DCT_MODE_FALL: ev[c] = fall[c]; // [RULE12] [RULE13]
          `DCT_MODE_RISE: ev[c] = rise[c];
          `DCT_MODE_DIV4: ev[c] = rise[c] && psc[c][1:0] == 2'b11; // [RULE24]
          `DCT_MODE_DIV16: ev[c] = rise[c] && psc[c] == 4'hf;
          default: ev[c] = 1'b0;
        endcase
      end
      trig[c] = ctrl[c][3:0] == `DCT_MODE_SPECIAL; // [RULE7]
    end
    trig[0] = trig[0] && compare_match_one;
    trig[1] = trig[1] && compare_match_two;
  end

  // prescaler runs only in capture; a change between settings keeps the count
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      psc[0] <= 4'h0;
      psc[1] <= 4'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!is_capture(ctrl[c])) begin
          psc[c] <= 4'h0; // [RULE21] [RULE14]
        end else if (rise[c] && ctrl[c][1]) begin
          psc[c] <= psc[c] + 4'h1; // [RULE22]
        end
      end
    end
  end

  // value bytes: a capture overwrites, and wins over a software write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int c = 0; c < 2; c++) begin
        val_lo[c] <= 8'h00;
        val_hi[c] <= 8'h00;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (ev[c]) begin
          val_lo[c] <= tval[c][7:0]; // [RULE11] [RULE16]
          val_hi[c] <= tval[c][15:8];
        end else if (wr_go) begin
          if (hit(avs_address, c == 0 ? `DCT_OFF_LOW1 : `DCT_OFF_LOW2)) begin
            val_lo[c] <= wbyte; // [RULE1]
          end
          if (hit(avs_address, c == 0 ? `DCT_OFF_HIGH1 : `DCT_OFF_HIGH2)) begin
            val_hi[c] <= wbyte;
          end
        end
      end
    end
  end

  // event flags: write one to clear, a capture in the same cycle wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flag <= 2'b00;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (ev[c]) begin
          flag[c] <= 1'b1; // [RULE15]
        end else if (wr_go && hit(avs_address, `DCT_OFF_STATUS) &&
                     wbyte[c]) begin
          flag[c] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      channel_irq_req <= 2'b00;
    end else begin
      channel_irq_req <= flag & irq_en;
    end
  end

  // special event triggers reset the assigned timer; conversion on two only
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      timer_one_reset <= 1'b0;
      timer_three_reset <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      timer_one_reset <= (trig[0] && base[0] == DCT_BASE_ONE) ||
                         (trig[1] && base[1] == DCT_BASE_ONE); // [RULE7]
      timer_three_reset <= (trig[0] && base[0] == DCT_BASE_THREE) ||
                           (trig[1] && base[1] == DCT_BASE_THREE); // [RULE6]
      adc_start <= trig[1]; // [RULE6]
    end
  end

  capture_low_a: assert property ( // [RULE11]
    @(posedge clk_sys) disable iff (!rstn)
    ev[0] |=> val_lo[0] == $past(tval[0][7:0]) &&
              val_hi[0] == $past(tval[0][15:8]))
    else $error("channel one capture did not latch the timer");

  overwrite_val_a: assert property ( // [RULE16]
    @(posedge clk_sys) disable iff (!rstn)
    ev[1] && flag[1] |=> val_hi[1] == $past(tval[1][15:8]))
    else $error("unread channel two value was not overwritten");

  flag_set_a: assert property ( // [RULE15]
    @(posedge clk_sys) disable iff (!rstn)
    ev[1] |=> flag[1] ##1 (flag[1] || $past(wr_go)))
    else $error("channel two flag not set by capture");

  flag_hold_a: assert property ( // [RULE15]
    @(posedge clk_sys) disable iff (!rstn)
    flag[0] && !(wr_go && hit(avs_address, `DCT_OFF_STATUS)) |=> flag[0])
    else $error("channel one flag dropped without software");

  psc_clear_a: assert property ( // [RULE21]
    @(posedge clk_sys) disable iff (!rstn)
    !is_capture(ctrl[0]) |=> psc[0] == 4'h0)
    else $error("prescaler not cleared outside capture");

  div_four_a: assert property ( // [RULE12]
    @(posedge clk_sys) disable iff (!rstn)
    ctrl[0][3:0] == `DCT_MODE_DIV4 && rise[0] && psc[0][1:0] != 2'b11
    |-> !ev[0])
    else $error("divide by four captured early");
  async_block_a: assert property ( // [RULE19]
    @(posedge clk_sys) disable iff (!rstn)
    tasync != 2'b00 |-> (ev & tasync) == 2'b00)
    else $error("capture taken from an asynchronous timer");
  route_pin_a: assert property ( // [RULE9]
    @(posedge clk_sys) disable iff (!rstn)
    pincfg[`DCT_PIN_SEL_BIT] && pincfg[`DCT_PIN_DIRC_BIT]
    |-> lvl[1] == filt[1])
    else $error("channel two not routed to port c");
  filt_agree_a: assert property ( // [RULE24]
    @(posedge clk_sys) disable iff (!rstn)
    $changed(filt[0]) |-> $past(sync[0][1]) == $past(sync[0][2]))
    else $error("pin level changed before stages agreed");
  adc_trig_a: assert property ( // [RULE6]
    @(posedge clk_sys) disable iff (!rstn)
    trig[1] |=> adc_start ##1 (adc_start == $past(trig[1])))
    else $error("conversion start does not follow channel two");
  bus_answer_a: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (avs_read || avs_write) && avs_waitrequest && bus_state == DCT_BUS_IDLE
    |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not one cycle after request");

endmodule

// ---- bench/dct_pin_src.sv ----
// external signal source model that drives one capture input pin
module dct_pin_src (
  input wire logic clk_sys,
  output logic pin
);
  timeunit 1ns;
  timeprecision 100ps;

  initial pin = 1'b0;

  // changes just after an edge; each level is held at least two cycles
  task automatic set_level(input logic v, input int hold);
    @(posedge clk_sys);
    pin <= v;
    repeat (hold) @(posedge clk_sys);
  endtask

  task automatic pulse(input int n, input int hold);
    repeat (n) begin
      set_level(1'b1, hold);
      set_level(1'b0, hold);
    end
  endtask
endmodule

// ---- bench/dct_top_tb.sv ----
// self-checking bench for the dual capture timer select block
`include "dct_map.svh"

module dct_top_tb;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pc_out, pc_oe_n, pb_out, pb_oe_n, p1, pcs, pbs, r1, r3, adc;
  logic [15:0] t1v = 16'h0;
  logic [15:0] t3v = 16'h0;
  logic a1 = 1'b0;
  logic a3 = 1'b0;
  logic cm1 = 1'b0;
  logic cm2 = 1'b0;
  logic [1:0] irq;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n1 = 0;
  int n3 = 0;
  int nadc = 0;
  // pin level seen by both parties: the device wins while it drives
  wire pc_wire = pc_oe_n ? pcs : pc_out;
  wire pb_wire = pb_oe_n ? pbs : pb_out;

  always #2 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (r1 === 1'b1) n1 <= n1 + 1;
    if (r3 === 1'b1) n3 <= n3 + 1;
    if (adc === 1'b1) nadc <= nadc + 1;
    if (cycles == 20000) begin
      bad_count++;
      test_done;
    end
  end

  dct_top dut_u (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .channel_one_pin(p1), .port_c_bit_one_pin(pc_wire),
    .port_b_bit_three_pin(pb_wire), .port_c_bit_one_out(pc_out),
    .port_c_bit_one_oe_n(pc_oe_n), .port_b_bit_three_out(pb_out),
    .port_b_bit_three_oe_n(pb_oe_n), .timer_one_value(t1v),
    .timer_three_value(t3v), .timer_one_async(a1),
    .timer_three_async(a3), .compare_match_one(cm1),
    .compare_match_two(cm2), .timer_one_reset(r1),
    .timer_three_reset(r3), .adc_start(adc), .channel_irq_req(irq));

  dct_pin_src src1_u (.clk_sys(clk_sys), .pin(p1));
  dct_pin_src srcc_u (.clk_sys(clk_sys), .pin(pcs));
  dct_pin_src srcb_u (.clk_sys(clk_sys), .pin(pbs));

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    chk("rdata upper", 8'h00, {7'h0, |avs_readdata[31:8]});
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input string what, input logic [5:0] a,
                    input logic [7:0] m, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(what, exp, q & m);
  endtask

  task automatic flag(input string what, input logic [7:0] m,
                      input logic [7:0] exp);
    rd(what, `DCT_OFF_STATUS, m, exp);
  endtask

  task automatic clr;
    wr(`DCT_OFF_STATUS, 8'h03);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic ch1(input int n, input int hold);
    src1_u.pulse(n, hold);
    tick(6);
  endtask

  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    tick(4);
    rstn <= 1'b1;
    rd("ctrl1", `DCT_OFF_CTRL1, 8'hff, 8'h00);
    rd("pincfg", `DCT_OFF_PINCFG, 8'hff, `DCT_PINCFG_RESET);
    chk("pc oe_n", 8'h01, {7'h0, pc_oe_n});
    wr(`DCT_OFF_CTRL2, 8'hff);
    rd("ctrl2", `DCT_OFF_CTRL2, 8'hff, `DCT_CTRL_MASK);
    wr(`DCT_OFF_LOW1, 8'ha5);
    rd("low1", `DCT_OFF_LOW1, 8'hff, 8'ha5);
    wr(`DCT_OFF_HIGH1, 8'h5a);
    rd("high1", `DCT_OFF_HIGH1, 8'hff, 8'h5a);
    wr(6'h28, 8'h77);
    rd("unmapped", 6'h28, 8'hff, 8'h00);
    wr(`DCT_OFF_CTRL2, `DCT_MODE_OFF);
    end_test("registers");
    t1v <= 16'h1234;
    t3v <= 16'habcd;
    wr(`DCT_OFF_CTRL1, `DCT_MODE_RISE);
    clr;
    ch1(1, 4);
    rd("low1 cap", `DCT_OFF_LOW1, 8'hff, 8'h34);
    rd("high1 cap", `DCT_OFF_HIGH1, 8'hff, 8'h12);
    flag("flag1", 8'h03, 8'h01);
    tick(40);
    flag("flag1 held", 8'h03, 8'h01);
    t1v <= 16'h5678;
    ch1(1, 4);
    rd("low1 over", `DCT_OFF_LOW1, 8'hff, 8'h78);
    rd("high1 over", `DCT_OFF_HIGH1, 8'hff, 8'h56);
    clr;
    flag("flag1 clr", 8'h03, 8'h00);
    src1_u.set_level(1'b1, 8);
    clr;
    src1_u.set_level(1'b0, 8);
    flag("fall ignored", 8'h03, 8'h00);
    end_test("rise");
    wr(`DCT_OFF_CTRL1, `DCT_MODE_OFF);
    wr(`DCT_OFF_T3CTRL, 8'h40);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_FALL);
    clr;
    ch1(1, 4);
    rd("low1 t3", `DCT_OFF_LOW1, 8'hff, 8'hcd);
    rd("high1 t3", `DCT_OFF_HIGH1, 8'hff, 8'hab);
    flag("fall cap", 8'h03, 8'h01);
    flag("bases three", 8'h3c, 8'h14);
    wr(`DCT_OFF_T3CTRL, 8'h08);
    flag("bases split", 8'h3c, 8'h10);
    wr(`DCT_OFF_CTRL2, 8'h0c);
    flag("base pwm", 8'h30, 8'h20);
    wr(`DCT_OFF_CTRL2, `DCT_MODE_OFF);
    end_test("time base");
    wr(`DCT_OFF_T3CTRL, 8'h00);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_OFF);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_DIV4);
    clr;
    ch1(3, 4);
    flag("div4 early", 8'h01, 8'h00);
    ch1(1, 4);
    flag("div4 final", 8'h01, 8'h01);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_OFF);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_DIV16);
    clr;
    ch1(15, 2);
    flag("div16 early", 8'h01, 8'h00);
    ch1(1, 2);
    flag("div16 final", 8'h01, 8'h01);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_OFF);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_DIV4);
    ch1(2, 2);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_DIV16);
    clr;
    ch1(13, 2);
    flag("switch early", 8'h01, 8'h00);
    ch1(1, 2);
    flag("switch final", 8'h01, 8'h01);
    end_test("prescale");
    wr(`DCT_OFF_CTRL1, `DCT_MODE_OFF);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_RISE);
    clr;
    a1 <= 1'b1;
    ch1(1, 4);
    flag("async", 8'h01, 8'h00);
    a1 <= 1'b0;
    wr(`DCT_OFF_T3CTRL, 8'h40);
    a3 <= 1'b1;
    ch1(1, 4);
    flag("async three", 8'h01, 8'h00);
    a3 <= 1'b0;
    wr(`DCT_OFF_T3CTRL, 8'h00);
    wr(`DCT_OFF_IRQEN, 8'h01);
    ch1(1, 4);
    chk("irq req", 8'h01, {6'h0, irq});
    wr(`DCT_OFF_IRQEN, 8'h00);
    end_test("async");
    wr(`DCT_OFF_CTRL2, `DCT_MODE_RISE);
    clr;
    srcb_u.pulse(1, 4);
    tick(6);
    flag("route c no b", 8'h02, 8'h00);
    srcc_u.pulse(1, 4);
    tick(6);
    flag("route c", 8'h02, 8'h02);
    rd("low2 cap", `DCT_OFF_LOW2, 8'hff, 8'h78);
    wr(`DCT_OFF_PINCFG, 8'h06);
    clr;
    srcb_u.pulse(1, 4);
    tick(6);
    flag("route b", 8'h02, 8'h02);
    wr(`DCT_OFF_PINCFG, 8'h02);
    tick(2);
    chk("pb oe_n", 8'h00, {7'h0, pb_oe_n});
    clr;
    wr(`DCT_OFF_PINCFG, 8'h12);
    tick(8);
    chk("pb out", 8'h01, {7'h0, pb_out});
    flag("port write cap", 8'h02, 8'h02);
    wr(`DCT_OFF_PINCFG, 8'h01);
    wr(`DCT_OFF_IRQEN, 8'h02);
    clr;
    wr(`DCT_OFF_PINCFG, 8'h09);
    tick(8);
    chk("pc out", 8'h01, {7'h0, pc_out});
    chk("pc oe_n drive", 8'h00, {7'h0, pc_oe_n});
    flag("latch c cap", 8'h02, 8'h02);
    chk("irq req2", 8'h02, {6'h0, irq});
    wr(`DCT_OFF_IRQEN, 8'h00);
    end_test("pin");
    wr(`DCT_OFF_T3CTRL, 8'h08);
    wr(`DCT_OFF_CTRL1, `DCT_MODE_SPECIAL);
    wr(`DCT_OFF_CTRL2, `DCT_MODE_SPECIAL);
    cm2 <= 1'b1;
    tick(1);
    cm2 <= 1'b0;
    tick(4);
    chk("t3 reset", 8'h01, n3[7:0]);
    chk("adc ch2", 8'h01, nadc[7:0]);
    chk("t1 quiet", 8'h00, n1[7:0]);
    cm1 <= 1'b1;
    tick(1);
    cm1 <= 1'b0;
    tick(4);
    chk("t1 reset", 8'h01, n1[7:0]);
    chk("adc ch1", 8'h01, nadc[7:0]);
    end_test("trigger");
    test_done;
  end
endmodule
